//--- i2st_bus_peer.sv
// Behavioural model of another master sharing the serial lines
`timescale 1ns/100ps
module i2st_bus_peer (
  // Device pull-down enables
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Resolved lines with pull-ups
  output logic scl_line,
  output logic sda_line
);
  logic scl_low_q = 1'b0;
  logic sda_low_q = 1'b0;
  // Wired-and: released lines float back high through the pull-ups
  assign scl_line = !(scl_oe || scl_low_q);
  assign sda_line = !(sda_oe || sda_low_q);
  // Start, then park the clock low so the bus stays owned
  task automatic frame_open();
    sda_low_q = 1'b1;
    #32 scl_low_q = 1'b1;
    #32 sda_low_q = 1'b0;
  endtask
  // Stop: data low, clock released, then data released
  task automatic frame_close();
    sda_low_q = 1'b1;
    #32 scl_low_q = 1'b0;
    #32 sda_low_q = 1'b0;
    #32;
  endtask
  // Pull data low to win arbitration against the device
  task automatic grab_data(input logic v);
    sda_low_q = v;
  endtask
endmodule

//--- i2st_line_if.sv
// Synchronised bus lines and bus events passed from the monitor to the core
`timescale 1ns/100ps
interface i2st_line_if;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic busy;
  modport mon (output scl_s, sda_s, start_det, stop_det, busy);
  modport core (input scl_s, sda_s, start_det, stop_det, busy);
endinterface

//--- i2st_line_mon.sv
// Pin synchroniser and start/stop detector for the shared bus
`timescale 1ns/100ps
module i2st_line_mon
  import i2st_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Raw pins
  input wire logic scl_in,
  input wire logic sda_in,
  // To the core
  i2st_line_if.mon line
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;
  logic busy_q;
  wire [1:0] raw = {scl_in, sda_in};

  // Two synchroniser flops and one edge flop per line; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
          prev_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= raw[i];
          sync_q[i] <= meta_q[i];
          prev_q[i] <= sync_q[i];
        end
      end
    end
  endgenerate

  // Data edges while the clock line stays high mark start and stop
  assign line.scl_s = sync_q[1];
  assign line.sda_s = sync_q[0];
  assign line.start_det = prev_q[1] & sync_q[1] & prev_q[0] & ~sync_q[0];
  assign line.stop_det = prev_q[1] & sync_q[1] & ~prev_q[0] & sync_q[0];
  assign line.busy = busy_q;

  // Bus owned by someone between a start and the next stop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else if (line.start_det) begin
      busy_q <= 1'b1;
    end else if (line.stop_det) begin
      busy_q <= 1'b0;
    end
  end
endmodule

//--- i2st_pkg.sv
// Constants, register map and state encoding of the start-condition trigger
package i2st_pkg;
  // Register byte addresses on the AXI4-Lite port
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_FLAG = 4'h4;
  localparam logic [3:0] OFF_RATE = 4'h8;
  // bus_control field positions
  localparam int CTRL_EN = 7;
  localparam int CTRL_REL = 6;
  localparam int CTRL_ACK = 2;
  localparam int CTRL_STT = 1;
  localparam int CTRL_SPT = 0;
  // flag_register field positions
  localparam int FLAG_STCF = 7;
  localparam int FLAG_BUSY = 6;
  localparam int FLAG_MST = 1;
  localparam int FLAG_RSVD = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  // Start hold time in ns and its cycle count at 200 MHz, rounded up
  localparam int HOLD_NS = 4000;
  localparam int CLK_PS = 5000;
  localparam int HOLD_CYC = (HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [15:0] RATE_RST = 16'(HOLD_CYC);
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Start sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RS_SDA = 3'b001,
    ST_RS_SCL = 3'b010,
    ST_HOLD = 3'b011,
    ST_SCL = 3'b100
  } i2st_state_t;
endpackage

//--- i2st_start_trig.sv
// Start-condition trigger with AXI4-Lite registers and open-drain line control
//
// How it works
// [R1] Trigger on free bus starts, becomes master
// [R2] Start: data falls while clock high
// [R3] After hold time, clock line driven low
// [R4] Busy bus, reservation on: wait, then start
// [R5] Busy bus, reservation off: failure flag, no start
// [R6] Master in wait: restart after wait release
// [R7] Software: no trigger mid master reception
// [R8] Software: set trigger in post-ninth wait
// [R9] Slave: trigger always reserves
// [R10] Software: never start and stop together
// [R11] Set trigger ignores further sets until cleared
// [R12] Failed set clears trigger after flag raised
// [R13] Arbitration loss clears trigger
// [R14] Generated start clears trigger
// [R15] Communication release write clears trigger
// [R16] Operation disable and reset clear trigger
// [R17] Read right after set returns 0
// [R18] Acknowledge enable holds data low ninth clock
// [R19] Hold time counted from rate register
// [R20] Arbitration lost: released high, sampled low
`timescale 1ns/100ps
module i2st_start_trig
  import i2st_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Open-drain bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Rest of the controller
  input wire logic wait_state,
  input wire logic slave_mode,
  input wire logic ninth_clk,
  input wire logic tx_release,
  input wire logic data_sda_oe,
  input wire logic ctrl_scl_oe,
  output logic master_active,
  output logic wait_release,
  output logic stop_request,
  output logic start_done,
  output logic arb_lost
);
  i2st_line_if line ();
  i2st_state_t state_q, state_d;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic en_q, ack_en_q, resv_dis_q, stt_q, stt_seen_q, stcf_q, fail_pend_q, master_q;
  logic [15:0] rate_q;
  logic [15:0] cnt_q;
  logic [1:0] oe_hist_q;

  // Bus monitor: synchronised lines, start/stop events, busy
  i2st_line_mon u_mon (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line)
  );

  // Write decode; address and data may arrive in either order
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_lane = wstrb_q[0];
  wire wr_map = (awaddr_q == OFF_CTRL) | (awaddr_q == OFF_FLAG) | (awaddr_q == OFF_RATE);
  wire wr_ctrl = wr_fire & (awaddr_q == OFF_CTRL) & wr_lane;
  wire wr_flag = wr_fire & (awaddr_q == OFF_FLAG) & wr_lane;
  wire wr_rate = wr_fire & (awaddr_q == OFF_RATE);
  wire ar_fire = s_axi_arvalid & ~rvalid_q;
  wire rd_map = (s_axi_araddr == OFF_CTRL) | (s_axi_araddr == OFF_FLAG) | (s_axi_araddr == OFF_RATE);

  // Control bit requests from a bus_control write
  wire both_trig = wdata_q[CTRL_STT] & wdata_q[CTRL_SPT];
  wire stt_req = wr_ctrl & wdata_q[CTRL_STT] & ~both_trig;
  wire rel_req = wr_ctrl & wdata_q[CTRL_REL];
  wire stt_ok = stt_req & ~stt_q & en_q; // [R11]
  wire other_busy = line.busy & ~master_q;
  wire stt_fail = stt_ok & other_busy & resv_dis_q & ~slave_mode; // [R5] [R9]
  wire start_fin = (state_q == ST_HOLD) & (cnt_q == 16'h0000);
  wire launch_ok = stt_q & ~fail_pend_q & en_q;

  // Arbitration check only after our data driver has been off long enough to be seen
  wire arb_chk = master_q & tx_release & ~sda_oe & (oe_hist_q == 2'b00);
  wire arb_hit = arb_chk & line.scl_s & ~line.sda_s; // [R20]
  wire abort = ~en_q | rel_req | arb_hit;
  wire stt_clr = abort | start_fin | fail_pend_q; // [R12] [R13] [R14] [R15] [R16]

  // Read data; the trigger reads 0 until it has been held a cycle
  wire stt_rd = stt_q & stt_seen_q; // [R17]
  wire [7:0] ctrl_rd = {en_q, 3'b000, 1'b0, ack_en_q, stt_rd, 1'b0};
  wire [7:0] flag_rd = {stcf_q, line.busy, 4'h0, master_q, resv_dis_q};
  wire [31:0] rd_mux = (s_axi_araddr == OFF_CTRL) ? {24'h000000, ctrl_rd} :
                       (s_axi_araddr == OFF_FLAG) ? {24'h000000, flag_rd} :
                       (s_axi_araddr == OFF_RATE) ? {16'h0000, rate_q} : 32'h00000000;

  // AXI handshakes are combinational, data and responses registered
  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready = ~w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write channel capture and response
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel, one cycle from address to data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Software settings: enable, acknowledge, reservation, hold-time rate
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= CTRL_RST[CTRL_EN];
      ack_en_q <= CTRL_RST[CTRL_ACK];
      resv_dis_q <= FLAG_RST[FLAG_RSVD];
      rate_q <= RATE_RST;
    end else begin
      if (wr_ctrl) begin
        en_q <= wdata_q[CTRL_EN];
        ack_en_q <= wdata_q[CTRL_ACK];
      end
      if (wr_flag) begin
        resv_dis_q <= wdata_q[FLAG_RSVD];
      end
      if (wr_rate & wstrb_q[0]) begin
        rate_q[7:0] <= wdata_q[7:0];
      end
      if (wr_rate & wstrb_q[1]) begin
        rate_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // Trigger bit; a clear takes priority since it ends the attempt
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stt_q <= CTRL_RST[CTRL_STT]; // [R16]
      stt_seen_q <= 1'b0;
      fail_pend_q <= 1'b0;
    end else begin
      stt_q <= stt_clr ? 1'b0 : (stt_q | stt_ok); // [R11]
      stt_seen_q <= stt_q & ~stt_clr;
      fail_pend_q <= stt_fail; // [R12]
    end
  end

  // Start failure flag; a new failure wins over the clearing retry
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stcf_q <= FLAG_RST[FLAG_STCF];
    end else if (stt_fail) begin
      stcf_q <= 1'b1; // [R5]
    end else if (stt_ok | ~en_q) begin
      stcf_q <= 1'b0;
    end
  end

  // Master ownership from our own start until stop, loss, release or disable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      master_q <= 1'b0;
    end else if (start_fin & ~abort) begin
      master_q <= 1'b1; // [R1]
    end else if (abort | line.stop_det) begin
      master_q <= 1'b0; // [R13]
    end
  end

  // Start sequencer; a restart first frees data then clock before the start
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (launch_ok & master_q & ~wait_state) begin
          state_d = ST_RS_SDA; // [R6]
        end else if (launch_ok & ~master_q & ~line.busy & line.scl_s & line.sda_s) begin
          state_d = ST_HOLD; // [R1] [R4] [R9]
        end
      end
      ST_RS_SDA: begin
        if (cnt_q == 16'h0000) begin
          state_d = ST_RS_SCL;
        end
      end
      ST_RS_SCL: begin
        if (cnt_q == 16'h0000) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt_q == 16'h0000) begin
          state_d = ST_SCL; // [R3]
        end
      end
      ST_SCL: begin
        if (ctrl_scl_oe) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (abort) begin
      state_d = ST_IDLE;
    end
  end

  // Hold counter reloads from the rate setting on every state change
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        cnt_q <= rate_q; // [R19]
      end else if (state_q == ST_RS_SCL & ~line.scl_s) begin
        cnt_q <= rate_q; // Clock may be stretched by a slave
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // Driver history so our own low is not mistaken for a lost bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_hist_q <= 2'b00;
    end else begin
      oe_hist_q <= {oe_hist_q[0], sda_oe};
    end
  end

  // Line drivers: open drain, so outputs stay low and enables pull
  wire seq_sda = (state_q == ST_HOLD) | (state_q == ST_SCL); // [R2]
  wire seq_scl = (state_q == ST_RS_SDA) | (state_q == ST_SCL); // [R3]
  wire ack_drv = ack_en_q & en_q & ninth_clk; // [R18]
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe = seq_sda | ack_drv | (data_sda_oe & ~(state_q == ST_RS_SDA) & ~(state_q == ST_RS_SCL));
  assign scl_oe = seq_scl | ctrl_scl_oe;

  // Handshakes to the rest of the controller
  assign master_active = master_q;
  assign wait_release = stt_ok & master_q & wait_state; // [R6]
  assign stop_request = wr_ctrl & wdata_q[CTRL_SPT] & ~both_trig & master_q & en_q;
  assign start_done = start_fin & ~abort; // [R14]
  assign arb_lost = arb_hit;

  // Checks against the trigger and the line sequence
  AST_START_ON_FREE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R1]
    (state_q == ST_IDLE) & launch_ok & ~master_q & ~line.busy & line.scl_s & line.sda_s & ~abort
    |=> (state_q == ST_HOLD) & sda_oe & ~seq_scl)
    else $error("start not launched on a free bus");
  AST_SDA_BEFORE_SCL: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R2]
    $rose(state_q == ST_SCL) |-> $past(sda_oe) & ~$past(seq_scl))
    else $error("clock pulled low before data fell");
  AST_HOLD_TIME: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R3]
    (state_q == ST_HOLD) & (cnt_q != 16'h0000) & ~abort |=> ~seq_scl)
    else $error("clock pulled low before hold ended");
  AST_RESERVE_WAIT: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R4]
    stt_q & ~master_q & line.busy & (state_q == ST_IDLE) |=> (state_q == ST_IDLE) | ~stt_q)
    else $error("start issued while bus busy");
  AST_FAIL_FLAG: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R5]
    stt_fail |=> stcf_q & (state_q == ST_IDLE) ##1 ~stt_q & (state_q == ST_IDLE))
    else $error("failed trigger did not flag and clear");
  AST_SET_IGNORED: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R11]
    stt_q & stt_req |-> ~stt_ok)
    else $error("second trigger set accepted");
  AST_CLR_ON_ABORT: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R13]
    arb_hit | rel_req | ~en_q |=> ~stt_q & ~master_q & (state_q == ST_IDLE))
    else $error("trigger survived loss, release or disable");
  AST_CLR_AFTER_START: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R14]
    start_done |=> ~stt_q & master_q & (state_q == ST_SCL) & scl_oe)
    else $error("trigger not cleared after start");
  AST_READ_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R17]
    $rose(stt_q) |-> ~stt_rd)
    else $error("trigger read as one right after set");
  AST_ACK_DRIVE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R18]
    ack_en_q & en_q & ninth_clk |-> sda_oe)
    else $error("acknowledge not driven");
endmodule

//--- test_i2c_start_condition_trigger.sv
// Self-checking testbench of the start-condition trigger
`timescale 1ns/100ps
module test_i2c_start_condition_trigger
  import i2st_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic scl_line, sda_line, scl_out, scl_oe, sda_out, sda_oe;
  logic wait_state = 1'b0, slave_mode = 1'b0, ninth_clk = 1'b0, tx_release = 1'b0;
  logic ctrl_scl_oe = 1'b0, data_oe = 1'b0;
  logic master_active, wait_release, stop_request, start_done, arb_lost;
  logic clr_seen = 1'b0;
  logic [3:0] seen_q = 4'h0;
  int err_total = 0;
  int check_count = 0;

  always #2.5 sys_clk = !sys_clk;

  i2st_start_trig DUT (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wait_state(wait_state),
    .slave_mode(slave_mode), .ninth_clk(ninth_clk), .tx_release(tx_release),
    .data_sda_oe(data_oe), .ctrl_scl_oe(ctrl_scl_oe), .master_active(master_active),
    .wait_release(wait_release), .stop_request(stop_request), .start_done(start_done),
    .arb_lost(arb_lost));

  i2st_bus_peer peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line));

  // Pulses are one cycle wide, so latch them: arb, done, stop, wait release
  always @(posedge sys_clk) begin
    if (clr_seen) seen_q <= 4'h0;
    else seen_q <= seen_q | {arb_lost, start_done, stop_request, wait_release};
  end

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No local limit: only the watchdog ends a wait
    forever begin
      @(negedge sys_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    s_axi_bready <= 1'b0;
    cmp_word({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic ar, rv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge sys_clk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) break;
    end
    s_axi_rready <= 1'b0;
    cmp_word({r, d}, {(a > 4'h8) ? RESP_SLVERR : RESP_OKAY, exp});
  endtask
  task automatic clear_seen();
    @(posedge sys_clk);
    clr_seen <= 1'b1;
    @(posedge sys_clk);
    clr_seen <= 1'b0;
  endtask
  // Watch n cycles for a pull on data; any pull means a start went out
  task automatic quiet(input int n, output logic any);
    any = 1'b0;
    repeat (n) begin
      @(negedge sys_clk);
      any = any | sda_oe;
    end
  endtask

  task automatic sc_reset();
    rd(OFF_CTRL, {24'h0, CTRL_RST});
    rd(OFF_FLAG, {24'h0, FLAG_RST});
    rd(OFF_RATE, 32'h320);
    rd(4'hc, 32'h0);
    wr(4'hc, 32'hff, RESP_SLVERR);
    // Byte lane 0 off: the flag write must leave reservation untouched
    s_axi_wstrb <= 4'h0;
    wr(OFF_FLAG, 32'h1, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(OFF_FLAG, {24'h0, FLAG_RST});
    wr(OFF_RATE, 32'h4, RESP_OKAY);
  endtask
  // Start on a free bus: data falls first, clock follows after rate+1 cycles
  task automatic sc_start();
    int n;
    clear_seen();
    // Enable first: a trigger in the enabling write meets a disabled block
    wr(OFF_CTRL, 32'h80, RESP_OKAY);
    wr(OFF_CTRL, 32'h82, RESP_OKAY);
    // Leave the response edge, where the sequencer is still updating
    @(negedge sys_clk);
    for (n = 0; n < 50 && !sda_oe; n++) @(negedge sys_clk);
    cmp_bit(scl_oe, 1'b0);
    cmp_bit(sda_out | scl_out, 1'b0);
    for (n = 0; n < 50 && !scl_oe; n++) @(negedge sys_clk);
    cmp_word(n, 32'd5);
    cmp_bit(seen_q[2], 1'b1);
    cmp_bit(master_active, 1'b1);
    rd(OFF_CTRL, 32'h80);
    ctrl_scl_oe <= 1'b1;
    @(posedge sys_clk);
    ctrl_scl_oe <= 1'b0;
  endtask
  // Reserved restart while in wait, then arbitration loss clears it
  task automatic sc_arb();
    clear_seen();
    wait_state <= 1'b1;
    wr(OFF_CTRL, 32'h82, RESP_OKAY);
    cmp_bit(seen_q[0], 1'b1);
    wr(OFF_CTRL, 32'h82, RESP_OKAY);
    rd(OFF_CTRL, 32'h82);
    // Own data driver on: a low line is ours, not a lost bit
    tx_release <= 1'b1;
    data_oe <= 1'b1;
    peer.grab_data(1'b1);
    repeat (10) @(negedge sys_clk);
    cmp_bit(seen_q[3], 1'b0);
    @(posedge sys_clk);
    data_oe <= 1'b0;
    repeat (10) @(negedge sys_clk);
    cmp_bit(seen_q[3], 1'b1);
    cmp_bit(master_active, 1'b0);
    rd(OFF_CTRL, 32'h80);
    peer.grab_data(1'b0);
    tx_release <= 1'b0;
    wait_state <= 1'b0;
    peer.frame_close();
  endtask
  // Restart once the wait is released, then disable drops mastership
  task automatic sc_restart();
    sc_start();
    wait_state <= 1'b1;
    wr(OFF_CTRL, 32'h82, RESP_OKAY);
    clear_seen();
    wait_state <= 1'b0;
    for (int n = 0; n < 200 && !seen_q[2]; n++) @(negedge sys_clk);
    cmp_bit(seen_q[2], 1'b1);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    @(negedge sys_clk);
    cmp_bit(master_active, 1'b0);
    peer.frame_close();
  endtask
  task automatic sc_busy();
    logic any;
    wr(OFF_FLAG, 32'h1, RESP_OKAY);
    wr(OFF_CTRL, 32'h80, RESP_OKAY);
    peer.frame_open();
    wr(OFF_CTRL, 32'h82, RESP_OKAY);
    quiet(20, any);
    cmp_bit(any, 1'b0);
    rd(OFF_FLAG, 32'hc1);
    rd(OFF_CTRL, 32'h80);
    // Reservation on: held until the peer stops, then issued
    wr(OFF_FLAG, 32'h0, RESP_OKAY);
    clear_seen();
    wr(OFF_CTRL, 32'h82, RESP_OKAY);
    quiet(20, any);
    cmp_bit(any, 1'b0);
    rd(OFF_CTRL, 32'h82);
    peer.frame_close();
    for (int n = 0; n < 200 && !seen_q[2]; n++) @(negedge sys_clk);
    cmp_bit(master_active, 1'b1);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    peer.frame_close();
  endtask
  // Slave always reserves; a release write withdraws the trigger
  task automatic sc_slave();
    @(posedge sys_clk);
    slave_mode <= 1'b1;
    wr(OFF_FLAG, 32'h1, RESP_OKAY);
    wr(OFF_CTRL, 32'h80, RESP_OKAY);
    peer.frame_open();
    wr(OFF_CTRL, 32'h82, RESP_OKAY);
    rd(OFF_FLAG, 32'h41);
    rd(OFF_CTRL, 32'h82);
    wr(OFF_CTRL, 32'hc0, RESP_OKAY);
    rd(OFF_CTRL, 32'h80);
    slave_mode <= 1'b0;
    peer.frame_close();
  endtask
  task automatic sc_misc();
    clear_seen();
    wr(OFF_CTRL, 32'h83, RESP_OKAY);
    rd(OFF_CTRL, 32'h80);
    cmp_bit(seen_q[1] | seen_q[2], 1'b0);
    wr(OFF_CTRL, 32'h84, RESP_OKAY);
    ninth_clk <= 1'b1;
    @(negedge sys_clk);
    cmp_bit(sda_oe, 1'b1);
    @(posedge sys_clk);
    ninth_clk <= 1'b0;
    // A receiver clears acknowledge before it may trigger again
    wr(OFF_CTRL, 32'h80, RESP_OKAY);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_CTRL, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sc_reset();
    sc_start();
    sc_arb();
    sc_restart();
    sc_busy();
    sc_slave();
    sc_misc();
    report_and_stop();
  end
  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule
